// file: design/gdfp_protect.v
// Fault detection and protection logic of a three-phase gate driver
`timescale 1ns/100ps
`include "gdfp_defines.vh"
module gdfp_protect #(
  parameter NUM_FETS    = 6,
  parameter TIMER_WIDTH = 11,
  parameter HOLD_COUNT  = `GDFP_HOLD_CYCLES,
  parameter QUICK_COUNT = `GDFP_QUICK_RESET_CYC
) (
  input  wire                    mclk_i,
  input  wire                    reset_n_i,
  input  wire                    logic_supply_uv_i,
  input  wire                    gate_supply_undervoltage_i,
  input  wire                    gate_supply_overvoltage_i,
  input  wire                    power_stage_undervoltage_i,
  input  wire [NUM_FETS-1:0]     oc_detect_i,
  input  wire [NUM_FETS-1:0]     pwm_i,
  input  wire                    ot_warning_i,
  input  wire                    ot_shutdown_i,
  input  wire                    enable_i,
  input  wire                    gate_reset_cmd_i,
  input  wire                    offset_calibration_pin_i,
  input  wire                    cfg_wr_i,
  input  wire [1:0]              cfg_gain_a_i,
  input  wire [1:0]              cfg_gain_b_i,
  input  wire [4:0]              cfg_oc_threshold_i,
  input  wire [1:0]              cfg_overcurrent_reaction_select_i,
  input  wire                    cfg_off_time_mode_i,
  input  wire [1:0]              cfg_warn_select_i,
  input  wire                    cfg_calibrate_i,
  input  wire                    fault_pin_i,
  input  wire                    warning_pin_i,
  output reg  [NUM_FETS-1:0]     gate_on_o,
  output reg                     gate_weak_pulldown_o,
  output reg                     charge_pump_en_o,
  output reg                     aux_blocks_en_o,
  output wire [1:0]              gain_a_o,
  output wire [1:0]              gain_b_o,
  output wire [4:0]              oc_threshold_o,
  output reg                     amp_input_short_o,
  output reg                     amp_load_disconnect_o,
  output reg  [`GDFP_ST_WIDTH-1:0] status_o,
  output wire                    fault_out_n_o,
  output reg                     fault_out_oe_n_o,
  output wire                    warning_out_n_o,
  output reg                     warning_out_oe_n_o
);

  localparam [TIMER_WIDTH-1:0] QUICK_MAX = QUICK_COUNT[TIMER_WIDTH-1:0];
  localparam [TIMER_WIDTH-1:0] CNT_ONE   = 1;

  // ==========================================================
  // Configuration registers
  reg [1:0]  gain_a_reg;
  reg [1:0]  gain_b_reg;
  reg [4:0]  threshold_reg;
  reg [1:0]  reaction_reg;
  reg        off_time_reg;
  reg [1:0]  warn_sel_reg;
  reg        cal_reg;

  assign gain_a_o       = gain_a_reg;
  assign gain_b_o       = gain_b_reg;
  assign oc_threshold_o = threshold_reg;

  // Held at defaults during logic undervoltage, so recovery leaves defaults
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_a_reg    <= `GDFP_GAIN_RST;
      gain_b_reg    <= `GDFP_GAIN_RST;
      threshold_reg <= `GDFP_THRESH_RST;
      reaction_reg  <= `GDFP_MODE_RST;
      off_time_reg  <= `GDFP_OFFTIME_RST;
      warn_sel_reg  <= `GDFP_WARN_SEL_RST;
      cal_reg       <= `GDFP_CAL_RST;
    end else if (logic_supply_uv_i) begin
      gain_a_reg    <= `GDFP_GAIN_RST;
      gain_b_reg    <= `GDFP_GAIN_RST;
      threshold_reg <= `GDFP_THRESH_RST;
      reaction_reg  <= `GDFP_MODE_RST;
      off_time_reg  <= `GDFP_OFFTIME_RST;
      warn_sel_reg  <= `GDFP_WARN_SEL_RST;
      cal_reg       <= `GDFP_CAL_RST;
    end else if (cfg_wr_i) begin
      gain_a_reg    <= cfg_gain_a_i;
      gain_b_reg    <= cfg_gain_b_i;
      threshold_reg <= cfg_oc_threshold_i;
      reaction_reg  <= cfg_overcurrent_reaction_select_i;
      off_time_reg  <= cfg_off_time_mode_i;
      warn_sel_reg  <= cfg_warn_select_i;
      cal_reg       <= cfg_calibrate_i;
    end
  end

  // ==========================================================
  // Enable pin: low-time measure, quick and full reset
  reg                   enable_prev_reg;
  reg [TIMER_WIDTH-1:0] low_cnt_reg;
  wire                  enable_rise = enable_i & ~enable_prev_reg;
  wire                  long_low    = (low_cnt_reg >= QUICK_MAX);
  wire                  fault_clear = enable_rise | gate_reset_cmd_i;
  wire                  ov_clear    = enable_rise & long_low;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_prev_reg <= 1'b0;
      low_cnt_reg     <= QUICK_MAX;
    end else begin
      enable_prev_reg <= enable_i;
      if (enable_i) begin
        low_cnt_reg <= {TIMER_WIDTH{1'b0}};
      end else if (!long_low) begin
        low_cnt_reg <= low_cnt_reg + CNT_ONE;
      end
    end
  end

  // ==========================================================
  // Latched faults; a new event wins over a clear
  reg ov_latch_reg;
  reg otsd_latch_reg;
  reg logic_uv_seen_reg;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ov_latch_reg      <= 1'b0;
      otsd_latch_reg    <= 1'b0;
      logic_uv_seen_reg <= 1'b0;
    end else begin
      if (gate_supply_overvoltage_i) begin
        ov_latch_reg <= 1'b1;
      end else if (ov_clear) begin
        ov_latch_reg <= 1'b0;
      end
      if (ot_shutdown_i) begin
        otsd_latch_reg <= 1'b1;
      end else if (fault_clear) begin
        otsd_latch_reg <= 1'b0;
      end
      if (logic_supply_uv_i) begin
        logic_uv_seen_reg <= 1'b1;
      end else if (fault_clear) begin
        logic_uv_seen_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Overcurrent handling per transistor; latch-mode shutdown per phase
  reg  [NUM_FETS-1:0] oc_prev_reg;
  reg  [NUM_FETS-1:0] pwm_prev_reg;
  reg  [NUM_FETS-1:0] block_reg;
  reg  [NUM_FETS-1:0] oc_cycle_reg;
  reg  [NUM_FETS/2-1:0] phase_latch_reg;
  wire [NUM_FETS-1:0] oc_evt;
  wire [NUM_FETS-1:0] pwm_rise;
  wire [NUM_FETS-1:0] pwm_edge;
  wire                oc_enabled = (reaction_reg != `GDFP_OC_OFF);
  wire                mode_limit = (reaction_reg == `GDFP_OC_LIMIT);
  wire                any_oc_evt = |oc_evt;
  wire                off_busy;
  wire                off_done;
  wire                warn_busy;

  assign oc_evt   = oc_detect_i & ~oc_prev_reg & {NUM_FETS{oc_enabled}};
  assign pwm_rise = pwm_i & ~pwm_prev_reg;
  assign pwm_edge = pwm_i ^ pwm_prev_reg;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oc_prev_reg  <= {NUM_FETS{1'b0}};
      pwm_prev_reg <= {NUM_FETS{1'b0}};
    end else begin
      oc_prev_reg  <= oc_detect_i;
      pwm_prev_reg <= pwm_i;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FETS; gi = gi + 1) begin : g_fet
      always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          block_reg[gi]    <= 1'b0;
          oc_cycle_reg[gi] <= 1'b0;
        end else begin
          if (mode_limit && oc_evt[gi]) begin
            block_reg[gi] <= 1'b1;
          end else if (!mode_limit) begin
            block_reg[gi] <= 1'b0;
          end else if (!off_time_reg && pwm_rise[gi]) begin
            block_reg[gi] <= 1'b0;
          end else if (off_time_reg && (pwm_edge[gi] || off_done)) begin
            block_reg[gi] <= 1'b0;
          end
          if (oc_evt[gi]) begin
            oc_cycle_reg[gi] <= 1'b1;
          end else if (pwm_edge[gi]) begin
            oc_cycle_reg[gi] <= 1'b0;
          end
        end
      end
      if (gi % 2 == 0) begin : g_phase
        always @(posedge mclk_i or negedge reset_n_i) begin
          if (!reset_n_i) begin
            phase_latch_reg[gi/2] <= 1'b0;
          end else if ((reaction_reg == `GDFP_OC_LATCH) && (oc_evt[gi] || oc_evt[gi+1])) begin
            phase_latch_reg[gi/2] <= 1'b1;
          end else if (fault_clear) begin
            phase_latch_reg[gi/2] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Shared off-time timer restarts on any new event
  gdfp_timer #(
    .WIDTH (TIMER_WIDTH),
    .COUNT (HOLD_COUNT)
  ) u_off_timer (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .start_i   (mode_limit & off_time_reg & any_oc_evt),
    .busy_o    (off_busy),
    .done_o    (off_done)
  );

  // Warning hold timer for overcurrent reporting
  gdfp_timer #(
    .WIDTH (TIMER_WIDTH),
    .COUNT (HOLD_COUNT)
  ) u_warn_timer (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .start_i   (any_oc_evt),
    .busy_o    (warn_busy),
    .done_o    ()
  );

  // ==========================================================
  // Gate drive, supply and calibration controls
  wire [NUM_FETS-1:0] phase_off;
  wire                driver_ok;
  wire                warn_oc;
  wire                warn_ot;
  wire                fault_any;
  wire [NUM_FETS-1:0] status_oc;

  generate
    for (gi = 0; gi < NUM_FETS; gi = gi + 1) begin : g_phase_map
      assign phase_off[gi] = phase_latch_reg[gi/2];
    end
  endgenerate

  assign driver_ok = enable_i & ~logic_supply_uv_i & ~gate_supply_undervoltage_i
                   & ~power_stage_undervoltage_i & ~ov_latch_reg & ~otsd_latch_reg;

  assign warn_oc = warn_busy & ((reaction_reg == `GDFP_OC_REPORT)
                 | (mode_limit & (|oc_cycle_reg)));
  assign warn_ot = ot_warning_i;

  assign fault_any = ~enable_i | logic_uv_seen_reg | logic_supply_uv_i
                   | gate_supply_undervoltage_i | ov_latch_reg
                   | power_stage_undervoltage_i | otsd_latch_reg | (|phase_latch_reg);

  assign status_oc = oc_evt;

  // Open-drain pins only ever pull low
  assign fault_out_n_o   = 1'b0;
  assign warning_out_n_o = 1'b0;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_on_o             <= {NUM_FETS{1'b0}};
      gate_weak_pulldown_o  <= 1'b0;
      charge_pump_en_o      <= 1'b0;
      aux_blocks_en_o       <= 1'b0;
      amp_input_short_o     <= 1'b0;
      amp_load_disconnect_o <= 1'b0;
      fault_out_oe_n_o      <= 1'b0;
      warning_out_oe_n_o    <= 1'b1;
    end else begin
      gate_on_o            <= pwm_i & ~block_reg & ~phase_off & {NUM_FETS{driver_ok}};
      gate_weak_pulldown_o <= logic_supply_uv_i;
      charge_pump_en_o     <= (enable_i | ~long_low) & ~ov_latch_reg & ~otsd_latch_reg;
      aux_blocks_en_o      <= enable_i | ~long_low;
      amp_input_short_o    <= cal_reg | offset_calibration_pin_i;
      amp_load_disconnect_o <= cal_reg | offset_calibration_pin_i;
      fault_out_oe_n_o     <= ~fault_any;
      case (warn_sel_reg)
        `GDFP_WARN_OT_ONLY: warning_out_oe_n_o <= ~warn_ot;
        `GDFP_WARN_OC_ONLY: warning_out_oe_n_o <= ~warn_oc;
        default:            warning_out_oe_n_o <= ~(warn_ot | warn_oc);
      endcase
    end
  end

  // ==========================================================
  // Status register: sticky, cleared by enable or gate reset; the gate overvoltage bit clears only on enable rising after a long low
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_o <= {`GDFP_ST_WIDTH{1'b0}};
    end else begin
      status_o[NUM_FETS-1:0] <= status_oc
                              | (status_o[NUM_FETS-1:0] & {NUM_FETS{~fault_clear}});
      status_o[`GDFP_ST_GATE_UV] <= gate_supply_undervoltage_i
                              | (status_o[`GDFP_ST_GATE_UV] & ~fault_clear);
      status_o[`GDFP_ST_GATE_OV] <= ov_latch_reg;
      status_o[`GDFP_ST_POWER_UV] <= power_stage_undervoltage_i
                              | (status_o[`GDFP_ST_POWER_UV] & ~fault_clear);
      status_o[`GDFP_ST_OT_WARN] <= ot_warning_i
                              | (status_o[`GDFP_ST_OT_WARN] & ~fault_clear);
      status_o[`GDFP_ST_OT_SD] <= otsd_latch_reg;
      status_o[`GDFP_ST_LOGIC_UV] <= logic_uv_seen_reg;
    end
  end

endmodule // gdfp_protect

// file: design/gdfp_defines.vh
// Constants of the gate driver fault protection block
`ifndef GDFP_DEFINES_VH
`define GDFP_DEFINES_VH

// ==========================================================
// Timing
`define GDFP_CLK_PERIOD_NS    40
`define GDFP_HOLD_TIME_NS     64000
`define GDFP_HOLD_CYCLES      (`GDFP_HOLD_TIME_NS / `GDFP_CLK_PERIOD_NS)
`define GDFP_QUICK_RESET_NS   10000
`define GDFP_QUICK_RESET_CYC  ((`GDFP_QUICK_RESET_NS + `GDFP_CLK_PERIOD_NS - 1) / `GDFP_CLK_PERIOD_NS)

// ==========================================================
// Overcurrent reaction encodings
`define GDFP_OC_LIMIT         2'h0
`define GDFP_OC_LATCH         2'h1
`define GDFP_OC_REPORT        2'h2
`define GDFP_OC_OFF           2'h3

// ==========================================================
// Warning output selection encodings
`define GDFP_WARN_BOTH        2'h0
`define GDFP_WARN_OT_ONLY     2'h1
`define GDFP_WARN_OC_ONLY     2'h2

// ==========================================================
// Configuration reset values
`define GDFP_GAIN_RST         2'h0
`define GDFP_THRESH_RST       5'h00
`define GDFP_MODE_RST         2'h0
`define GDFP_OFFTIME_RST      1'b0
`define GDFP_WARN_SEL_RST     2'h0
`define GDFP_CAL_RST          1'b0

// ==========================================================
// Status bit positions; bits 5..0 are per-transistor overcurrent
`define GDFP_ST_GATE_UV       6
`define GDFP_ST_GATE_OV       7
`define GDFP_ST_POWER_UV      8
`define GDFP_ST_OT_WARN       9
`define GDFP_ST_OT_SD         10
`define GDFP_ST_LOGIC_UV      11
`define GDFP_ST_WIDTH         12

`endif

// file: design/gdfp_timer.v
// Restartable countdown timer with a busy level and an expiry pulse
`timescale 1ns/100ps
module gdfp_timer #(
  parameter WIDTH = 11,
  parameter COUNT = 1600
) (
  input  wire mclk_i,
  input  wire reset_n_i,
  input  wire start_i,
  output wire busy_o,
  output reg  done_o
);

  localparam [WIDTH-1:0] LOAD = COUNT[WIDTH-1:0];
  localparam [WIDTH-1:0] ZERO = 0;
  localparam [WIDTH-1:0] ONE  = 1;

  reg [WIDTH-1:0] count_reg;

  assign busy_o = (count_reg != ZERO);

  // ==========================================================
  // Counter: start reloads at any time, restarting a running count
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= ZERO;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        count_reg <= LOAD;
      end else if (count_reg != ZERO) begin
        count_reg <= count_reg - ONE;
        if (count_reg == ONE) begin
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule // gdfp_timer

// file: test/gdfp_protect_assertions.sv
// Concurrent checks on the ports of the gate driver fault protection block
`timescale 1ns/100ps
`include "gdfp_defines.vh"
module gdfp_checker (
  input wire        mclk_i,
  input wire        reset_n_i,
  input wire        logic_supply_uv_i,
  input wire        gate_supply_undervoltage_i,
  input wire        gate_supply_overvoltage_i,
  input wire        power_stage_undervoltage_i,
  input wire        ot_shutdown_i,
  input wire        enable_i,
  input wire        gate_reset_cmd_i,
  input wire        offset_calibration_pin_i,
  input wire        cfg_wr_i,
  input wire [1:0]  cfg_gain_a_i,
  input wire [1:0]  cfg_gain_b_i,
  input wire [5:0]  gate_on_o,
  input wire        gate_weak_pulldown_o,
  input wire        charge_pump_en_o,
  input wire        aux_blocks_en_o,
  input wire [1:0]  gain_a_o,
  input wire [1:0]  gain_b_o,
  input wire        amp_input_short_o,
  input wire        amp_load_disconnect_o,
  input wire [11:0] status_o,
  input wire        fault_out_n_o,
  input wire        fault_out_oe_n_o,
  input wire        warning_out_n_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  // ==========================================================
  // Short enable low pulse while the other blocks are up
  sequence s_quick_low;
    aux_blocks_en_o && $fell(enable_i) ##1 !enable_i [*4];
  endsequence

  chk_weak_pulldown: assert property (
    logic_supply_uv_i |=> gate_weak_pulldown_o && gate_on_o == 6'h00)
    else $error("gates not weakly pulled low in logic undervoltage");
  chk_gate_uv_off: assert property (
    gate_supply_undervoltage_i |=> gate_on_o == 6'h00 && !fault_out_oe_n_o)
    else $error("gate supply undervoltage not acted on");
  chk_power_uv_off: assert property (
    power_stage_undervoltage_i |=> gate_on_o == 6'h00)
    else $error("gates on in power stage undervoltage");
  chk_ov_shutdown: assert property (
    gate_supply_overvoltage_i |-> ##2 !charge_pump_en_o && gate_on_o == 6'h00
      && status_o[`GDFP_ST_GATE_OV])
    else $error("overvoltage did not shut down driver and pump");
  chk_ot_shutdown: assert property (
    ot_shutdown_i |-> ##2 status_o[`GDFP_ST_OT_SD] && !charge_pump_en_o && !fault_out_oe_n_o)
    else $error("thermal shutdown not latched or not reported");
  chk_gain_load: assert property (
    cfg_wr_i && !logic_supply_uv_i |=> gain_a_o == $past(cfg_gain_a_i)
      && gain_b_o == $past(cfg_gain_b_i))
    else $error("gain setting not taken");
  chk_cal_pin: assert property (
    offset_calibration_pin_i |=> amp_input_short_o && amp_load_disconnect_o)
    else $error("calibration pin did not short the amplifier");
  chk_fault_not_ready: assert property (
    !enable_i |=> !fault_out_oe_n_o)
    else $error("fault released while driver not ready");
  chk_ov_kept: assert property (
    status_o[`GDFP_ST_GATE_OV] && gate_reset_cmd_i && enable_i && $stable(enable_i)
      |=> status_o[`GDFP_ST_GATE_OV])
    else $error("gate reset cleared the overvoltage latch");
  chk_quick_reset: assert property (
    s_quick_low |-> aux_blocks_en_o)
    else $error("short enable pulse shut down other blocks");
  chk_open_drain: assert property (
    fault_out_n_o == 1'b0 && warning_out_n_o == 1'b0)
    else $error("open-drain output value not low");
endmodule // gdfp_checker

bind gdfp_protect gdfp_checker u_gdfp_checker (
  .mclk_i, .reset_n_i, .logic_supply_uv_i, .gate_supply_undervoltage_i,
  .gate_supply_overvoltage_i, .power_stage_undervoltage_i, .ot_shutdown_i, .enable_i,
  .gate_reset_cmd_i, .offset_calibration_pin_i, .cfg_wr_i, .cfg_gain_a_i, .cfg_gain_b_i,
  .gate_on_o, .gate_weak_pulldown_o, .charge_pump_en_o, .aux_blocks_en_o, .gain_a_o,
  .gain_b_o, .amp_input_short_o, .amp_load_disconnect_o, .status_o, .fault_out_n_o,
  .fault_out_oe_n_o, .warning_out_n_o
);

// file: test/gdfp_mcu_model.sv
// Motor controller model: PWM, enable pin and pulled-up fault lines
`timescale 1ns/100ps
module gdfp_mcu_model (
  input  wire        mclk_i,
  input  wire        fault_oe_n_i,
  input  wire        warning_oe_n_i,
  input  wire        fault_out_n_i,
  input  wire        warning_out_n_i,
  output logic [5:0] pwm_o,
  output logic       enable_o,
  output wire        fault_pin_o,
  output wire        warning_pin_o
);
  initial begin
    pwm_o = 6'h00;
    enable_o = 1'b0;
  end
  // Pull-ups hold both lines high when released
  assign fault_pin_o   = fault_oe_n_i ? 1'b1 : fault_out_n_i;
  assign warning_pin_o = warning_oe_n_i ? 1'b1 : warning_out_n_i;
  task automatic drive(input logic [5:0] p, input logic e);
    pwm_o = p;
    enable_o = e;
  endtask
  task automatic pulse_enable(input int len);
    enable_o = 1'b0;
    repeat (len) @(negedge mclk_i);
    enable_o = 1'b1;
  endtask
endmodule // gdfp_mcu_model

// file: test/test_gate_driver_fault_protection.sv
// Self-checking testbench of the gate driver fault protection block
`timescale 1ns/100ps
`include "gdfp_defines.vh"
module test_gate_driver_fault_protection;
  logic        mclk_i = 0;
  logic        reset_n_i = 0;
  logic        luv = 0, guv = 0, gov = 0, puv = 0, otw = 0, ots = 0;
  logic        grst = 0, calp = 0, wr = 0, cal = 0, offt = 0;
  logic [5:0]  oc = 0;
  logic [1:0]  ga = 0, gb = 0, mode = 0, wsel = 0;
  logic [4:0]  thr = 0;
  wire  [5:0]  pwm, gate;
  wire         en, fpin, wpin, wpd, pump, aux, ashort, adisc, fo, foe, wo, woe;
  wire  [1:0]  gao, gbo;
  wire  [4:0]  thro;
  wire  [11:0] st;
  int          n_mismatch = 0, check_count = 0, cycles = 0;

  always #20 mclk_i = ~mclk_i;

  gdfp_protect #(.HOLD_COUNT(16), .QUICK_COUNT(8)) u_gdfp_protect (
    .mclk_i, .reset_n_i, .logic_supply_uv_i(luv), .gate_supply_undervoltage_i(guv),
    .gate_supply_overvoltage_i(gov), .power_stage_undervoltage_i(puv), .oc_detect_i(oc),
    .pwm_i(pwm), .ot_warning_i(otw), .ot_shutdown_i(ots), .enable_i(en),
    .gate_reset_cmd_i(grst), .offset_calibration_pin_i(calp), .cfg_wr_i(wr),
    .cfg_gain_a_i(ga), .cfg_gain_b_i(gb), .cfg_oc_threshold_i(thr),
    .cfg_overcurrent_reaction_select_i(mode), .cfg_off_time_mode_i(offt),
    .cfg_warn_select_i(wsel), .cfg_calibrate_i(cal), .fault_pin_i(fpin),
    .warning_pin_i(wpin), .gate_on_o(gate), .gate_weak_pulldown_o(wpd),
    .charge_pump_en_o(pump), .aux_blocks_en_o(aux), .gain_a_o(gao), .gain_b_o(gbo),
    .oc_threshold_o(thro), .amp_input_short_o(ashort), .amp_load_disconnect_o(adisc),
    .status_o(st), .fault_out_n_o(fo), .fault_out_oe_n_o(foe), .warning_out_n_o(wo),
    .warning_out_oe_n_o(woe)
  );

  gdfp_mcu_model u_gdfp_mcu_model (
    .mclk_i, .fault_oe_n_i(foe), .warning_oe_n_i(woe), .fault_out_n_i(fo),
    .warning_out_n_i(wo), .pwm_o(pwm), .enable_o(en), .fault_pin_o(fpin),
    .warning_pin_o(wpin)
  );

  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic [1:0] m, input logic o, input logic [1:0] w);
    mode = m;
    offt = o;
    wsel = w;
    wr = 1;
    cyc(1);
    wr = 0;
  endtask
  task automatic gate_reset;
    grst = 1;
    cyc(1);
    grst = 0;
  endtask
  task automatic oc_pulse(input logic [5:0] v);
    oc = v;
    cyc(1);
    oc = 0;
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ==========================================================
  // Test sequence
  initial begin
    cyc(5);
    reset_n_i = 1;
    u_gdfp_mcu_model.drive(6'h3F, 1'b1);
    cyc(3);
    chk(foe, 1);
    chk(gate, 6'h3F);
    for (int i = 0; i < 4; i++) begin
      ga = i[1:0];
      gb = ~i[1:0];
      thr = {i[1:0], 3'h5};
      wr = 1;
      cyc(1);
      wr = 0;
      chk({gao, gbo}, {ga, gb});
      chk(thro, thr);
    end
    calp = 1;
    cyc(2);
    chk({ashort, adisc}, 2'h3);
    calp = 0;
    cal = 1;
    cfg(0, 0, 0);
    cyc(2);
    chk({ashort, adisc}, 2'h3);
    cal = 0;
    cfg(2, 0, 0);
    cyc(2);
    chk({ashort, adisc}, 2'h0);
    oc_pulse(6'h02);
    cyc(1);
    chk({woe, foe, st[1], gate}, {3'h3, 6'h3F});
    cyc(8);
    chk(woe, 0);
    cyc(12);
    chk(woe, 1);
    gate_reset();
    cfg(3, 0, 0);
    oc_pulse(6'h08);
    cyc(3);
    chk({woe, st}, {1'b1, 12'h000});
    cfg(1, 0, 0);
    oc_pulse(6'h04);
    cyc(3);
    chk(gate, 6'h33);
    gate_reset();
    cyc(2);
    chk(gate, 6'h3F);
    cfg(0, 0, 0);
    oc_pulse(6'h10);
    cyc(9);
    oc_pulse(6'h20);
    cyc(12);
    chk({woe, gate}, {1'b0, 6'h0F});
    cyc(8);
    chk(woe, 1);
    u_gdfp_mcu_model.drive(6'h0F, 1'b1);
    cyc(1);
    u_gdfp_mcu_model.drive(6'h3F, 1'b1);
    cyc(2);
    chk(gate, 6'h3F);
    cfg(0, 1, 0);
    oc_pulse(6'h01);
    cyc(4);
    oc_pulse(6'h02);
    cyc(2);
    u_gdfp_mcu_model.drive(6'h3D, 1'b1);
    cyc(1);
    u_gdfp_mcu_model.drive(6'h3F, 1'b1);
    cyc(4);
    chk(gate, 6'h3E);
    cyc(12);
    chk(gate, 6'h3F);
    puv = 1;
    cyc(2);
    chk({foe, gate}, 7'h00);
    puv = 0;
    guv = 1;
    cyc(2);
    chk({st[`GDFP_ST_GATE_UV], gate}, 7'h40);
    guv = 0;
    gov = 1;
    cyc(1);
    gov = 0;
    cyc(2);
    chk({pump, gate}, 7'h00);
    gate_reset();
    cyc(2);
    chk(st[`GDFP_ST_GATE_OV], 1);
    u_gdfp_mcu_model.pulse_enable(6);
    cyc(2);
    chk({st[`GDFP_ST_GATE_OV], aux}, 2'h3);
    u_gdfp_mcu_model.pulse_enable(12);
    cyc(3);
    chk({st[`GDFP_ST_GATE_OV], gate}, 7'h3F);
    cfg(2, 0, 2);
    otw = 1;
    cyc(2);
    chk(woe, 1);
    cfg(2, 0, 1);
    cyc(2);
    chk(woe, 0);
    otw = 0;
    oc_pulse(6'h01);
    cyc(2);
    chk(woe, 1);
    cyc(16);
    cfg(2, 0, 0);
    otw = 1;
    cyc(2);
    chk(woe, 0);
    otw = 0;
    ots = 1;
    cyc(2);
    ots = 0;
    cyc(3);
    chk({foe, gate}, 7'h00);
    chk(gao, 2'h3);
    gate_reset();
    cyc(2);
    chk(gate, 6'h3F);
    luv = 1;
    cyc(2);
    chk({wpd, gate}, 7'h40);
    luv = 0;
    cyc(2);
    chk({gao, foe, st[`GDFP_ST_LOGIC_UV]}, 4'h1);
    close_out();
  end
endmodule // test_gate_driver_fault_protection
